/* logic/tfcr_regs.sv */
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module tfcr_regs #(
  parameter logic [3:0] OPTION_CODE = 4'h5  // Arbitrary value
) (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic [tfcr_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [tfcr_pkg::AXI_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [31:0]                           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  input  wire logic                             cs_n,
  output logic [tfcr_pkg::IDX_W-1:0]            lut_index,
  input  wire tfcr_pkg::tfcr_codes_t            lut_codes,
  input  wire tfcr_pkg::tfcr_codes_t            interp_codes,
  output tfcr_pkg::tfcr_codes_t                 applied_codes
);
  import tfcr_pkg::*;

  logic [9:0]  aw_ix_q,  aw_ix_d;
  logic        aw_hold_q, aw_hold_d;
  logic [7:0]  w_data_q, w_data_d;
  logic        w_lane_q, w_lane_d;
  logic        w_hold_q, w_hold_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q,  bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q,  rdata_d;
  logic [1:0]  rresp_q,  rresp_d;
  logic [6:0]  stop_q,   stop_d;
  logic [6:0]  start_q,  start_d;
  logic        dir_q,    dir_d;
  logic        interp_q, interp_d;
  logic        tmode_q,  tmode_d;
  logic [6:0]  idx_q,    idx_d;
  tfcr_codes_t staged_q, staged_d;
  tfcr_codes_t applied_q, applied_d;
  logic        cs_meta_q, cs_sync_q, cs_last_q;
  logic        cs_rise;
  logic        write_go;
  tfcr_sel_t   wsel;
  tfcr_sel_t   rsel;
  logic [7:0]  rbyte;

  // Chip select rises when the select pin goes high
  assign cs_rise = cs_sync_q & ~cs_last_q;
  assign write_go = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wsel = tfcr_decode(aw_ix_q);
  assign rsel = tfcr_decode(s_axi_araddr[AXI_ADDR_W-1:2]);

  assign s_axi_awready = ~aw_hold_q;
  assign s_axi_wready  = ~w_hold_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign lut_index     = idx_q;
  assign applied_codes = applied_q;

  always_comb
  begin
    rbyte = 8'h00;
    unique case (rsel)
      SEL_OPTION: rbyte = {4'h0, OPTION_CODE};              // [RQ10]
      SEL_STOP:   rbyte = {1'b0, stop_q};                    // [RQ1]
      SEL_START:  rbyte = {1'b0, start_q};                   // [RQ2]
      SEL_DIR:    rbyte = {7'h00, dir_q};                    // [RQ3]
      SEL_NEXT:   rbyte = {1'b0, idx_q};                     // [RQ5]
      SEL_STG_FC: rbyte = staged_q.center;                   // [RQ7]
      SEL_STG_BW: rbyte = staged_q.bandwidth;
      SEL_STG_MT: rbyte = staged_q.matching;
      SEL_CONFIG: rbyte = {7'h00, interp_q};
      SEL_MODE:   rbyte = {7'h00, tmode_q};
      SEL_APP_FC: rbyte = applied_q.center;                  // [RQ9]
      SEL_APP_BW: rbyte = applied_q.bandwidth;
      SEL_APP_MT: rbyte = applied_q.matching;
      SEL_NONE:   rbyte = 8'h00;
    endcase
  end

  always_comb
  begin
    aw_ix_d   = aw_ix_q;
    aw_hold_d = aw_hold_q;
    w_data_d  = w_data_q;
    w_lane_d  = w_lane_q;
    w_hold_d  = w_hold_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    stop_d    = stop_q;
    start_d   = start_q;
    dir_d     = dir_q;
    interp_d  = interp_q;
    tmode_d   = tmode_q;
    idx_d     = idx_q;
    staged_d  = staged_q;
    applied_d = applied_q;

    // Address and data are taken in either order and held
    if (s_axi_awvalid && !aw_hold_q)
    begin
      aw_ix_d   = s_axi_awaddr[AXI_ADDR_W-1:2];
      aw_hold_d = 1'b1;
    end
    if (s_axi_wvalid && !w_hold_q)
    begin
      w_data_d = s_axi_wdata[7:0];
      w_lane_d = s_axi_wstrb[0];
      w_hold_d = 1'b1;
    end
    if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;

    if (write_go)
    begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      // Only byte lane 0 carries register bits
      if (w_lane_q)
      begin
        unique case (wsel)
          SEL_STOP:   stop_d = w_data_q[6:0];               // [RQ1]
          SEL_START:  start_d = w_data_q[6:0];              // [RQ2]
          SEL_DIR:    dir_d = w_data_q[DIR_BIT];            // [RQ3]
          SEL_STG_FC: staged_d.center = w_data_q;           // [RQ7]
          SEL_STG_BW: staged_d.bandwidth = w_data_q;        // [RQ7]
          SEL_STG_MT: staged_d.matching = w_data_q;         // [RQ7]
          SEL_CONFIG: interp_d = w_data_q[INTERP_BIT];
          SEL_MODE:   tmode_d = w_data_q[MODE_BIT];
          default:    ;
        endcase
      end
    end

    if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rdata_d  = {24'h000000, rbyte};
      rresp_d  = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end

    // Bound changes outrank a coincident select edge so the
    // sequence always restarts from the newly written bounds
    if (write_go && w_lane_q &&
        (wsel == SEL_STOP || wsel == SEL_START || wsel == SEL_DIR))
      idx_d = dir_d ? stop_d : start_d;                      // [RQ4] [RQ6]
    else if (tmode_q && cs_rise)
    begin
      if (!dir_q)
        idx_d = (idx_q == stop_q) ? start_q : idx_q + 7'd1;  // [RQ11]
      else
        idx_d = (idx_q == start_q) ? stop_q : idx_q - 7'd1;  // [RQ11]
    end

    if (tmode_q)
    begin
      if (cs_rise)
        applied_d = lut_codes;                               // [RQ11] [RQ12]
    end
    else if (interp_q)
      applied_d = interp_codes;                              // [RQ8] [RQ12]
    else
      applied_d = staged_q;                                  // [RQ8] [RQ12]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ix_q   <= 10'h000;
      aw_hold_q <= 1'b0;
      w_data_q  <= 8'h00;
      w_lane_q  <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
      stop_q    <= RST_STOP;                                 // [RQ1]
      start_q   <= RST_START;                                // [RQ2]
      dir_q     <= RST_DIR;                                  // [RQ3]
      interp_q  <= RST_FLAG;
      tmode_q   <= RST_FLAG;
      idx_q     <= RST_START;                                // [RQ5]
      staged_q  <= {RST_CODE, RST_CODE, RST_CODE};
      applied_q <= {RST_CODE, RST_CODE, RST_CODE};
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_last_q <= 1'b1;
    end
    else
    begin
      aw_ix_q   <= aw_ix_d;
      aw_hold_q <= aw_hold_d;
      w_data_q  <= w_data_d;
      w_lane_q  <= w_lane_d;
      w_hold_q  <= w_hold_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      stop_q    <= stop_d;
      start_q   <= start_d;
      dir_q     <= dir_d;
      interp_q  <= interp_d;
      tmode_q   <= tmode_d;
      idx_q     <= idx_d;
      staged_q  <= staged_d;
      applied_q <= applied_d;
      cs_meta_q <= cs_n;
      cs_sync_q <= cs_meta_q;
      cs_last_q <= cs_sync_q;
    end
  end

endmodule : tfcr_regs
`default_nettype wire

/* logic/tfcr_pkg.sv */
// Summary of operation
// RQ1: Stop index bits 6:0, resets 0x7F, bit7 zero.
// RQ2: Start index bits 6:0, resets zero, bit7 zero.
// RQ3: Direction bit 0: zero increments, one decrements.
// RQ4: Index loads start when incrementing, stop otherwise.
// RQ5: Readback shows index used at next select rise.
// RQ6: Start, stop or direction writes reload index.
// RQ7: Three staged code registers, eight bits, reset zero.
// RQ8: Interpolation enable picks computed over staged codes.
// RQ9: Applied codes read back at 0x060 to 0x062.
// RQ10: Option code bits 3:0, upper bits read zero.
// RQ11: Select rise applies entry, steps, wraps within bounds.
// RQ12: Readback always mirrors the codes driving the filter.
`default_nettype none
package tfcr_pkg;

  localparam int unsigned AXI_ADDR_W = 12;
  localparam int unsigned IDX_W      = 7;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IX_OPTION   = 10'h00C;
  localparam logic [9:0] IX_STOP     = 10'h011;
  localparam logic [9:0] IX_START    = 10'h012;
  localparam logic [9:0] IX_DIR      = 10'h013;
  localparam logic [9:0] IX_NEXT     = 10'h014;
  localparam logic [9:0] IX_STG_FC   = 10'h020;
  localparam logic [9:0] IX_STG_BW   = 10'h021;
  localparam logic [9:0] IX_STG_MT   = 10'h022;
  localparam logic [9:0] IX_CONFIG   = 10'h050;
  localparam logic [9:0] IX_MODE     = 10'h051;
  localparam logic [9:0] IX_APP_FC   = 10'h060;
  localparam logic [9:0] IX_APP_BW   = 10'h061;
  localparam logic [9:0] IX_APP_MT   = 10'h062;

  localparam int unsigned DIR_BIT    = 0;
  localparam int unsigned INTERP_BIT = 0;
  localparam int unsigned MODE_BIT   = 0;

  localparam logic [6:0] RST_STOP    = 7'h7F;
  localparam logic [6:0] RST_START   = 7'h00;
  localparam logic       RST_DIR     = 1'b0;
  localparam logic [7:0] RST_CODE    = 8'h00;
  localparam logic       RST_FLAG    = 1'b0;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0] center;
    logic [7:0] bandwidth;
    logic [7:0] matching;
  } tfcr_codes_t;

  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_OPTION,
    SEL_STOP,
    SEL_START,
    SEL_DIR,
    SEL_NEXT,
    SEL_STG_FC,
    SEL_STG_BW,
    SEL_STG_MT,
    SEL_CONFIG,
    SEL_MODE,
    SEL_APP_FC,
    SEL_APP_BW,
    SEL_APP_MT
  } tfcr_sel_t;

  function automatic tfcr_sel_t tfcr_decode(input logic [9:0] ix);
    tfcr_sel_t s;
    s = SEL_NONE;
    unique case (ix)
      IX_OPTION: s = SEL_OPTION;
      IX_STOP:   s = SEL_STOP;
      IX_START:  s = SEL_START;
      IX_DIR:    s = SEL_DIR;
      IX_NEXT:   s = SEL_NEXT;
      IX_STG_FC: s = SEL_STG_FC;
      IX_STG_BW: s = SEL_STG_BW;
      IX_STG_MT: s = SEL_STG_MT;
      IX_CONFIG: s = SEL_CONFIG;
      IX_MODE:   s = SEL_MODE;
      IX_APP_FC: s = SEL_APP_FC;
      IX_APP_BW: s = SEL_APP_BW;
      IX_APP_MT: s = SEL_APP_MT;
      default:   s = SEL_NONE;
    endcase
    return s;
  endfunction : tfcr_decode

endpackage : tfcr_pkg
`default_nettype wire

/* bench/tfcr_regs_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module tfcr_regs_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        cs_n,
  input wire logic [6:0]  lut_index
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Wide window since the select synchroniser depth is a design choice
  logic [5:0] cs_h_q;
  logic       stp;
  always_ff @(posedge aclk)
  begin
    if (!aresetn) cs_h_q <= 6'h3F;
    else cs_h_q <= {cs_h_q[4:0], cs_n};
  end
  assign stp = |(cs_h_q[4:0] & ~cs_h_q[5:1]);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after both taken");
  chk_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before accepted");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before accepted");
  chk_rdata_upper: assert property (
    s_axi_rvalid |-> !(|s_axi_rdata[31:8]))
    else $error("read data upper bits not zero");
  chk_read_release: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data still valid after accepted");
  chk_reset_index: assert property ($rose(aresetn) |-> lut_index == 7'h00)
    else $error("index not zero after reset");
  chk_index_cause: assert property ($changed(lut_index)
    |-> $rose(s_axi_bvalid) || stp)
    else $error("index moved without write or select rise");
endmodule : tfcr_regs_monitor
bind tfcr_regs tfcr_regs_monitor u_tfcr_regs_monitor (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cs_n,
  .lut_index);
`default_nettype wire

/* bench/tfcr_lut_model.sv */
`timescale 1ns/100ps
`default_nettype none
module tfcr_lut_model (
  input wire logic [6:0]         lut_index,
  output tfcr_pkg::tfcr_codes_t  lut_codes
);
  import tfcr_pkg::*;
  // Each field coded differently so a wrong index shows in all three
  assign lut_codes = {1'b1, lut_index, {lut_index, 1'b0} ^ 8'h5A,
                      ~{1'b0, lut_index}};
endmodule : tfcr_lut_model
`default_nettype wire

/* bench/test_tunable_filter_control_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module test_tunable_filter_control_regs;
  import tfcr_pkg::*;
  logic aclk, aresetn, cs_n, awv, wv, arv, awr, wr_, bv, arr, rv, dir;
  logic br, rr;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdd;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  logic [6:0] idx, cur, s;
  tfcr_codes_t lutc, intc, app, stg;
  integer num_errors, total_checks, cycles, seed, i;
  logic [9:0] rix [12] = '{IX_OPTION, IX_STOP, IX_START, IX_DIR, IX_NEXT,
    IX_STG_FC, IX_STG_BW, IX_STG_MT, IX_CONFIG, IX_APP_FC, IX_APP_BW,
    IX_APP_MT};
  tfcr_regs #(.OPTION_CODE(4'hA)) u_tfcr_regs (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .cs_n(cs_n), .lut_index(idx),
    .lut_codes(lutc), .interp_codes(intc), .applied_codes(app));
  tfcr_lut_model u_tfcr_lut_model (.lut_index(idx), .lut_codes(lutc));
  function automatic logic [23:0] exp_lut(input logic [6:0] k);
    return {1'b1, k, {k, 1'b0} ^ 8'h5A, ~{1'b0, k}};
  endfunction : exp_lut
  function automatic logic [6:0] nxt(input logic [6:0] k, lo, hi,
                                     input logic d);
    if (d) return (k == lo) ? hi : k - 7'h01;
    return (k == hi) ? lo : k + 7'h01;
  endfunction : nxt
  task automatic check(input string n, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [9:0] ix, input logic [7:0] d,
                    input logic [3:0] st = 4'hF);
    logic ta, tw, da, dw;
    {da, dw} = 2'b00;
    awa <= {ix, 2'b00};
    wd <= {$random(seed) & 32'hFFFFFF00} | d;
    ws <= st;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = awr && !da;
      tw = wr_ && !dw;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end while (!(da && dw));
    // A late bready makes the response stand for a while
    repeat ($random(seed) & 3) @(posedge aclk);
    br <= 1'b1;
    do @(negedge aclk); while (!bv);
    @(posedge aclk);
    br <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] ix);
    ara <= {ix, 2'b00};
    arv <= 1'b1;
    do @(negedge aclk); while (!arr);
    @(posedge aclk);
    arv <= 1'b0;
    repeat ($random(seed) & 3) @(posedge aclk);
    rr <= 1'b1;
    do @(negedge aclk); while (!rv);
    @(posedge aclk);
    rr <= 1'b0;
  endtask : rd
  task automatic pulse;
    cs_n <= 1'b0;
    repeat (10) @(posedge aclk);
    cs_n <= 1'b1;
    repeat (10) @(posedge aclk);
  endtask : pulse
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      stop_test();
    end
  end
  initial
  begin
    {aresetn, awv, wv, arv, cs_n, br, rr} = 7'b0000100;
    {awa, ara, wd, ws} = 60'h0;
    {num_errors, total_checks, cycles, seed} = {96'h0, 32'd59};
    intc = 24'($random(seed));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 12; i++)
    begin
      rd(rix[i]);
      check("reset value", rdd, (i == 0) ? 8'h0A : (i == 1) ? 8'h7F : 8'h00);
    end
    for (i = 0; i < 12; i++)
    begin
      wr(rix[i], 8'hFF);
      rd(rix[i]);
      check("after ones", rdd, (i > 8) ? intc[23 - 8 * (i - 9) -: 8] : (i == 0) ? 8'h0A : (i == 3 || i == 8) ? 8'h01 : (i < 5) ? 8'h7F : 8'hFF);
    end
    wr(10'h3FF, 8'h55);
    check("unmapped write", bresp, RESP_SLVERR);
    rd(10'h3FF);
    check("unmapped read resp", rresp, RESP_SLVERR);
    check("unmapped read data", rdd, 32'h0);
    wr(IX_CONFIG, 8'h00);
    stg = 24'($random(seed));
    for (i = 0; i < 3; i++) wr(rix[5 + i], stg[23 - 8 * i -: 8]);
    // Lane 0 off: the staged code must stay as written above
    wr(IX_STG_FC, ~stg.center, 4'hE);
    check("mapped write", bresp, RESP_OKAY);
    rd(IX_APP_BW);
    check("mapped read", rresp, RESP_OKAY);
    check("applied port", app, stg);
    check("applied read", rdd, stg.bandwidth);
    wr(IX_MODE, 8'h01);
    for (i = 0; i < 2; i++)
    begin
      dir = i[0];
      s = 7'($random(seed)) & 7'h3F;
      wr(IX_STOP, {1'b0, s + 7'h03});
      wr(IX_START, {1'b0, s});
      wr(IX_DIR, {7'h00, dir});
      cur = dir ? s + 7'h03 : s;
      rd(IX_NEXT);
      check("reload index", rdd, cur);
      check("reload port", idx, cur);
      repeat (5)
      begin
        pulse();
        check("stepped codes", app, exp_lut(cur));
        cur = nxt(cur, s, s + 7'h03, dir);
        rd(IX_NEXT);
        check("next index", rdd, cur);
        check("index port", idx, cur);
      end
    end
    stop_test();
  end
endmodule : test_tunable_filter_control_regs
`default_nettype wire
